//--- pot_consts.svh
// Constants for the dual potentiometer serial command decoder.
`ifndef POT_CONSTS_SVH
`define POT_CONSTS_SVH

`define POS_W           6
`define PAD_W           2
`define POS_MAX         6'h3f
`define POS_MIN         6'h00
`define POTS            2
`define SLOTS           4
`define BYTE_BITS       4'h8
`define CNT_ZERO        4'h0
`define CNT_ONE         4'h1
`define CNT_TWO         4'h2
`define RECALL_SLOT     2'h0
`define SLOT_INIT_DEF   6'h00
`define TYPE_PREFIX_DEF 4'h9 // Arbitrary type prefix value.
`define INS_ZERO_BIT    3
`define INS_POT_BIT     2
`define OP_RD_WIPER     4'h9
`define OP_WR_WIPER     4'ha
`define OP_RD_SLOT      4'hb
`define OP_WR_SLOT      4'hc
`define OP_SLOT2W       4'hd
`define OP_W2SLOT       4'he
`define OP_G_SLOT2W     4'h1
`define OP_G_W2SLOT     4'h8
`define OP_STEP         4'h2
`define NV_CNT_W        21
`define NV_WRITE_TIME_NS 5000000
`define MCLK_PERIOD_NS  4

`endif

//--- pot_pkg.sv
// Types shared by the potentiometer command decoder.
`default_nettype none
`include "pot_consts.svh"

package pot_pkg;

  typedef logic [`POS_W-1:0]                       pos_t;
  typedef logic [`POTS-1:0][`POS_W-1:0]            wiper_pair_t;
  typedef logic [`POTS-1:0][`SLOTS-1:0][`POS_W-1:0] slot_bank_t;

  // Pins sampled from outside the clock domain.
  typedef struct packed {
    logic       scl;
    logic       sda;
    logic [3:0] strap;
  } pins_t;

  typedef enum logic [3:0] {
    S_RECALL    = 4'h0,
    S_IDLE      = 4'h1,
    S_ADDR      = 4'h3,
    S_ADDR_ACK  = 4'h2,
    S_INSTR     = 4'h6,
    S_INSTR_ACK = 4'h7,
    S_WDATA     = 4'h5,
    S_WDATA_ACK = 4'h4,
    S_RDATA     = 4'hc,
    S_RDATA_ACK = 4'hd,
    S_STEP      = 4'hf,
    S_WAIT      = 4'he
  } state_t;

  typedef struct packed {
    state_t                 state;
    logic [3:0]             cnt;
    logic [7:0]             shift;
    logic [7:0]             instr;
    logic                   sda_oe_n;
    logic                   sda_o;
    logic                   scl_p;
    logic                   sda_p;
    wiper_pair_t            wiper;
    slot_bank_t             slots;
    logic                   pend_v;
    logic [`POTS-1:0]       pend_mask;
    logic [1:0]             pend_slot;
    wiper_pair_t            pend_val;
    logic                   nv_busy;
    logic [`NV_CNT_W-1:0]   nv_cnt;
  } ctrl_t;

endpackage

`default_nettype wire

//--- pin_sync.sv
// Two-flop synchroniser for a group of pins.
`default_nettype none

module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         srst,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  // The first stage feeds only the second stage.
  // Reset lands on the bus idle level, so no false edge is seen after reset.
  always_ff @(posedge mclk) begin
    if (srst) begin
      meta_q <= '1;
      q      <= '1;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

`default_nettype wire

//--- pot_frame_ctrl.sv
// Serial command frame decoder for two 64-step potentiometers with stored settings.
//
// Notes on behaviour
// - A frame opens with start and an address of prefix and straps, acked only on a match.
// - Read-wiper returns the selected wiper in one byte, then an ack cycle and stop.
// - Write-wiper takes one data byte, acks it and loads the selected wiper before stop.
// - Read-setting returns the chosen pot and slot value as one byte.
// - Write-setting takes one data byte, acks it and stores it in the chosen slot.
// - The global slot-to-wiper copy loads every pot's chosen slot into its wiper.
// - The global wiper-to-slot copy stores every pot's wiper into its chosen slot.
// - The single wiper-to-slot copy stores the chosen pot's wiper into its chosen slot.
// - The single slot-to-wiper copy loads the chosen slot into the chosen pot's wiper.
// - The step command is acked and then followed by any number of direction bits until stop.
// - Programming of a stored slot begins only after the stop has been seen.
// - Each step clock with data high moves the wiper up one, with data low down one, and the wiper holds at either end.
// - The two slot bits pick slot 0 to 3 in binary order.
// - A stored slot change completes within 5 ms.
// - At power-up each wiper is loaded from slot 0.
`default_nettype none
`include "pot_consts.svh"

module pot_frame_ctrl #(
  parameter logic [3:0]           TYPE_PREFIX     = `TYPE_PREFIX_DEF, // Arbitrary value.
  parameter logic [`POS_W-1:0]    SLOT_INIT       = `SLOT_INIT_DEF,
  parameter logic [`NV_CNT_W-1:0] NV_WRITE_CYCLES =
    `NV_CNT_W'(`NV_WRITE_TIME_NS / `MCLK_PERIOD_NS)
) (
  input  wire logic                mclk,
  input  wire logic                srst,
  input  wire pot_pkg::pins_t      pins,
  output var  logic                sda_out,
  output var  logic                sda_oe_n,
  output var  pot_pkg::wiper_pair_t wiper_position_register,
  output var  logic                nv_busy
);
  import pot_pkg::*;

  pins_t p;
  ctrl_t st_q;
  ctrl_t st_d;
  logic  scl_rise;
  logic  scl_fall;
  logic  start_det;
  logic  stop_det;
  logic  ins_pot;
  logic [1:0] ins_slot;
  logic [3:0] ins_op;

  pin_sync #(.W($bits(pins_t))) u_sync (
    .mclk (mclk),
    .srst (srst),
    .d    (pins),
    .q    (p)
  );

  // Bus events seen on the resynchronised pins; the link clock is slow enough to oversample.
  assign scl_rise  = p.scl & ~st_q.scl_p;
  assign scl_fall  = ~p.scl & st_q.scl_p;
  assign start_det = p.scl & st_q.scl_p & st_q.sda_p & ~p.sda;
  assign stop_det  = p.scl & st_q.scl_p & ~st_q.sda_p & p.sda;
  assign ins_op    = st_q.instr[7:4];
  assign ins_pot   = st_q.instr[`INS_POT_BIT];
  assign ins_slot  = st_q.instr[1:0];

  // One-hot pot mask from a pot select bit.
  function automatic logic [`POTS-1:0] pot_mask(input logic sel);
    pot_mask = sel ? 2'b10 : 2'b01;
  endfunction

  // Accept only the instruction codes the device knows, with their fixed zero bits.
  function automatic logic legal_instr(input logic [7:0] ins);
    logic zero_ok;
    zero_ok = ~ins[`INS_ZERO_BIT];
    case (ins[7:4])
      `OP_RD_SLOT, `OP_WR_SLOT, `OP_SLOT2W, `OP_W2SLOT: legal_instr = zero_ok;
      `OP_RD_WIPER, `OP_WR_WIPER, `OP_STEP:
        legal_instr = zero_ok & (ins[1:0] == 2'h0);
      `OP_G_SLOT2W, `OP_G_W2SLOT: legal_instr = zero_ok & ~ins[`INS_POT_BIT];
      default: legal_instr = 1'b0;
    endcase
  endfunction

  // Next-state logic for the whole block.
  always_comb begin
    st_d       = st_q;
    st_d.scl_p = p.scl;
    st_d.sda_p = p.sda;
    st_d.sda_o = 1'b0;
    // Programming timer; slots change only when it expires, so a read never sees a half write.
    if (st_q.nv_busy) begin
      if (st_q.nv_cnt == NV_WRITE_CYCLES - `NV_CNT_W'(1)) begin
        st_d.nv_busy = 1'b0;
        st_d.pend_v  = 1'b0;
        for (int i = 0; i < `POTS; i++) begin
          if (st_q.pend_mask[i]) begin
            st_d.slots[i][st_q.pend_slot] = st_q.pend_val[i];
          end
        end
      end else begin
        st_d.nv_cnt = st_q.nv_cnt + `NV_CNT_W'(1);
      end
    end
    if (stop_det) begin
      st_d.state    = S_IDLE;
      st_d.sda_oe_n = 1'b1;
      if (st_q.pend_v && !st_q.nv_busy) begin
        st_d.nv_busy = 1'b1;
        st_d.nv_cnt  = '0;
      end
    end else if (start_det && st_q.state != S_RECALL) begin
      st_d.state    = S_ADDR;
      st_d.cnt      = `CNT_ZERO;
      st_d.sda_oe_n = 1'b1;
    end else begin
      case (st_q.state)
        S_RECALL: begin
          for (int i = 0; i < `POTS; i++) begin
            st_d.wiper[i] = st_q.slots[i][`RECALL_SLOT];
          end
          st_d.state = S_IDLE;
        end
        S_ADDR, S_INSTR, S_WDATA: begin
          if (scl_rise) begin
            st_d.shift = {st_q.shift[6:0], p.sda};
            st_d.cnt   = st_q.cnt + `CNT_ONE;
          end else if (scl_fall && st_q.cnt == `BYTE_BITS) begin
            st_d.state    = S_WAIT;
            if (st_q.state == S_ADDR) begin
              // Refuse the frame while a slot is being programmed.
              if (st_q.shift == {TYPE_PREFIX, p.strap} && !st_q.nv_busy) begin
                st_d.state    = S_ADDR_ACK;
                st_d.sda_oe_n = 1'b0;
              end
            end else if (st_q.state == S_INSTR) begin
              if (legal_instr(st_q.shift)) begin
                st_d.instr    = st_q.shift;
                st_d.state    = S_INSTR_ACK;
                st_d.sda_oe_n = 1'b0;
              end
            end else begin
              st_d.state    = S_WDATA_ACK;
              st_d.sda_oe_n = 1'b0;
              if (ins_op == `OP_WR_WIPER) begin
                st_d.wiper[ins_pot] = st_q.shift[`POS_W-1:0];
              end else begin
                st_d.pend_v             = 1'b1;
                st_d.pend_mask          = pot_mask(ins_pot);
                st_d.pend_slot          = ins_slot;
                st_d.pend_val[ins_pot]  = st_q.shift[`POS_W-1:0];
              end
            end
          end
        end
        S_ADDR_ACK, S_WDATA_ACK: begin
          if (scl_fall) begin
            st_d.sda_oe_n = 1'b1;
            st_d.cnt      = `CNT_ZERO;
            st_d.state    = (st_q.state == S_ADDR_ACK) ? S_INSTR : S_WAIT;
          end
        end
        S_INSTR_ACK: begin
          if (scl_fall) begin
            st_d.sda_oe_n = 1'b1;
            st_d.cnt      = `CNT_ZERO;
            st_d.state    = S_WAIT;
            case (ins_op)
              `OP_RD_WIPER, `OP_RD_SLOT: begin
                st_d.state = S_RDATA;
                st_d.shift = {{`PAD_W{1'b0}}, (ins_op == `OP_RD_WIPER) ?
                              st_q.wiper[ins_pot] : st_q.slots[ins_pot][ins_slot]};
                st_d.sda_oe_n = 1'b0; // Upper bit is always zero.
              end
              `OP_WR_WIPER, `OP_WR_SLOT: st_d.state = S_WDATA;
              `OP_STEP: st_d.state = S_STEP;
              `OP_SLOT2W: st_d.wiper[ins_pot] = st_q.slots[ins_pot][ins_slot];
              `OP_G_SLOT2W: begin
                for (int i = 0; i < `POTS; i++) begin
                  st_d.wiper[i] = st_q.slots[i][ins_slot];
                end
              end
              `OP_W2SLOT, `OP_G_W2SLOT: begin
                st_d.pend_v    = 1'b1;
                st_d.pend_mask = (ins_op == `OP_W2SLOT) ? pot_mask(ins_pot) : '1;
                st_d.pend_slot = ins_slot;
                st_d.pend_val  = st_q.wiper;
              end
              default: st_d.state = S_WAIT;
            endcase
          end
        end
        S_RDATA: begin
          if (scl_rise) begin
            st_d.cnt = st_q.cnt + `CNT_ONE;
          end else if (scl_fall) begin
            if (st_q.cnt == `BYTE_BITS) begin
              st_d.sda_oe_n = 1'b1;
              st_d.state    = S_RDATA_ACK;
            end else begin
              st_d.shift    = {st_q.shift[6:0], 1'b0};
              st_d.sda_oe_n = st_q.shift[6];
            end
          end
        end
        S_RDATA_ACK: begin
          if (scl_fall) begin
            st_d.state = S_WAIT;
          end
        end
        S_STEP: begin
          // Direction is taken at the rise and applied at the fall, so the rise of a stop
          // never steps; saturate at the ends rather than wrap, so a long burst parks the wiper.
          if (scl_rise) begin
            st_d.shift = {st_q.shift[6:0], p.sda};
          end else if (scl_fall) begin
            if (st_q.shift[0] && st_q.wiper[ins_pot] != `POS_MAX) begin
              st_d.wiper[ins_pot] = st_q.wiper[ins_pot] + `POS_W'(1);
            end else if (!st_q.shift[0] && st_q.wiper[ins_pot] != `POS_MIN) begin
              st_d.wiper[ins_pot] = st_q.wiper[ins_pot] - `POS_W'(1);
            end
          end
        end
        S_IDLE, S_WAIT: st_d.state = st_q.state;
        default: st_d.state = S_IDLE;
      endcase
    end
  end

  // State register; stored slots start from the factory image at reset.
  always_ff @(posedge mclk) begin
    if (srst) begin
      st_q           <= '0;
      st_q.state     <= S_RECALL;
      st_q.sda_oe_n  <= 1'b1;
      st_q.slots     <= {(`POTS * `SLOTS){SLOT_INIT}};
      st_q.scl_p     <= 1'b1;
      st_q.sda_p     <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign sda_out                 = st_q.sda_o;
  assign sda_oe_n                = st_q.sda_oe_n;
  assign wiper_position_register = st_q.wiper;
  assign nv_busy                 = st_q.nv_busy;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  sequence step_up_s;
    st_q.state == S_STEP && scl_fall && st_q.shift[0] && !stop_det && !start_det
      && st_q.wiper[ins_pot] != `POS_MAX;
  endsequence
  sequence step_dn_s;
    st_q.state == S_STEP && scl_fall && !st_q.shift[0] && !stop_det && !start_det
      && st_q.wiper[ins_pot] != `POS_MIN;
  endsequence

  chk_addr_ack_match: assert property (
    st_q.state == S_ADDR_ACK |-> st_q.shift == {TYPE_PREFIX, p.strap} && !sda_oe_n)
    else $error("Address acknowledged without a matching address.");
  chk_step_up_one: assert property (
    step_up_s |=> st_q.wiper[ins_pot] == $past(st_q.wiper[ins_pot]) + `POS_W'(1))
    else $error("Step up did not move the wiper by one.");
  chk_step_down_one: assert property (
    step_dn_s |=> st_q.wiper[ins_pot] == $past(st_q.wiper[ins_pot]) - `POS_W'(1))
    else $error("Step down did not move the wiper by one.");
  chk_prog_after_stop: assert property (
    $rose(nv_busy) |-> $past(stop_det) && $past(st_q.pend_v))
    else $error("Programming started without a stop.");
  chk_prog_time_bound: assert property (
    nv_busy |-> st_q.nv_cnt < NV_WRITE_CYCLES)
    else $error("Programming ran past its time.");
  chk_slots_held_busy: assert property (
    !(nv_busy && st_q.nv_cnt == NV_WRITE_CYCLES - `NV_CNT_W'(1)) |=> $stable(st_q.slots))
    else $error("A stored slot changed outside the programming end.");
  chk_recall_slot0: assert property (
    st_q.state == S_RECALL && !stop_det |=>
      st_q.wiper[0] == st_q.slots[0][0] && st_q.wiper[1] == st_q.slots[1][0])
    else $error("Wiper not loaded from slot 0 at power-up.");
  chk_read_pad_zero: assert property (
    st_q.state == S_RDATA && st_q.cnt < `CNT_TWO |-> !sda_oe_n)
    else $error("Upper read bits not driven as zero.");
  chk_wdata_ack_held: assert property (
    $rose(st_q.state == S_WDATA_ACK) |-> !sda_oe_n[*2])
    else $error("Data byte acknowledge not driven.");
  chk_wiper_write_load: assert property (
    st_q.state == S_WDATA && scl_fall && st_q.cnt == `BYTE_BITS && ins_op == `OP_WR_WIPER
      && !stop_det && !start_det |=> st_q.wiper[ins_pot] == $past(st_q.shift[`POS_W-1:0]))
    else $error("Written wiper value not loaded.");

endmodule

`default_nettype wire

//--- host_master.sv
// Behavioural two-wire bus master that frames commands for the pot decoder.
`default_nettype none

module host_master (
  input  wire logic mclk,
  input  wire logic sda,
  output var  logic scl,
  output var  logic sda_m
);
  timeunit 1ns;
  timeprecision 1ps;

  // The bus idles with both lines released, so the clock stands still between frames.
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // One bit cell is 12 mclk (48 ns); data moves mid-low and is sampled mid-high.
  task automatic bit_io(input logic b, output logic s);
    tick(3);
    sda_m = b;
    tick(3);
    scl = 1'b1;
    tick(3);
    s = sda;
    tick(3);
    scl = 1'b0;
  endtask

  // A falling data line under a high clock opens the frame.
  task automatic start_c();
    sda_m = 1'b0;
    tick(6);
    scl = 1'b0;
  endtask

  // A rising data line under a high clock closes it.
  task automatic stop_c();
    tick(3);
    sda_m = 1'b0;
    tick(3);
    scl = 1'b1;
    tick(6);
    sda_m = 1'b1;
    tick(6);
  endtask

  // Eight bits most significant first, then a released ninth bit for the acknowledge.
  task automatic byte_io(input logic [7:0] b, output logic [7:0] r, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
      r[i] = s;
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask

  // Kind 0 copy, 1 write, 2 read, 3 eight direction bits taken from dat.
  task automatic xfer(input logic [7:0] adr, input logic [7:0] ins, input logic [7:0] dat,
                      input int kind, output logic [7:0] rd, output logic [2:0] ack);
    logic [7:0] junk;
    logic       s;
    start_c();
    byte_io(adr, junk, ack[2]);
    byte_io(ins, junk, ack[1]);
    ack[0] = 1'b0;
    rd = 8'h00;
    if (kind == 1) byte_io(dat, junk, ack[0]);
    if (kind == 2) byte_io(8'hff, rd, ack[0]);
    if (kind == 3) for (int i = 7; i >= 0; i--) bit_io(dat[i], s);
    stop_c();
  endtask
endmodule

`default_nettype wire

//--- pot_frame_ctrl_test.sv
// Self-checking bench for the potentiometer command decoder.
`default_nettype none
`include "pot_consts.svh"

module pot_frame_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  import pot_pkg::*;

  localparam logic [7:0] ADR  = 8'h96;
  localparam logic [5:0] INIT = 6'h2a;

  logic        mclk;
  logic        srst;
  logic        scl;
  logic        sda_m;
  logic        sda;
  logic        sda_out;
  logic        sda_oe_n;
  logic        nv_busy;
  pins_t       pins;
  wiper_pair_t wiper;
  logic [7:0]  rd;
  logic [3:0]  strap;
  logic [2:0]  ack;
  int          num_errors;
  int          n_checks;
  int          cycles;

  // Open-drain wire with a pull-up: either party pulling low wins.
  assign sda = sda_m & (sda_oe_n | sda_out);
  assign pins = '{scl: scl, sda: sda, strap: strap};

  host_master host_u (.mclk(mclk), .sda(sda), .scl(scl), .sda_m(sda_m));

  pot_frame_ctrl #(.TYPE_PREFIX(4'h9), .SLOT_INIT(INIT), .NV_WRITE_CYCLES(`NV_CNT_W'(20)))
    dut_u (.mclk(mclk), .srst(srst), .pins(pins), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
           .wiper_position_register(wiper), .nv_busy(nv_busy));

  // Free-running 250 MHz clock.
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Programming must wait for the stop, so the busy flag is looked at on both sides of it.
  task automatic nv_frame(input logic [7:0] ins, input logic [7:0] dat, input logic has_dat);
    logic [7:0] junk;
    logic       a;
    host_u.start_c();
    host_u.byte_io(ADR, junk, a);
    host_u.byte_io(ins, junk, a);
    if (has_dat) host_u.byte_io(dat, junk, a);
    check("busy before stop", {7'h0, nv_busy}, 8'h00);
    host_u.stop_c();
    check("busy after stop", {7'h0, nv_busy}, 8'h01);
    for (int i = 0; i < 60 && nv_busy !== 1'b0; i++) @(negedge mclk);
    check("busy done", {7'h0, nv_busy}, 8'h00);
  endtask

  // A hang is cut short well beyond the few thousand cycles the frames need.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      conclude();
    end
  end

  // Main sequence of command frames.
  initial begin
    srst = 1'b1;
    strap = 4'h6;
    num_errors = 0;
    n_checks = 0;
    cycles = 0;
    repeat (4) @(negedge mclk);
    srst = 1'b0;
    repeat (8) @(negedge mclk);
    check("recall wiper0", {2'h0, wiper[0]}, {2'h0, INIT});
    check("recall wiper1", {2'h0, wiper[1]}, {2'h0, INIT});
    host_u.xfer(ADR, 8'ha4, 8'hd5, 1, rd, ack);
    check("write wiper acks", {5'h0, ack}, 8'h07);
    check("wiper1 written", {2'h0, wiper[1]}, 8'h15);
    check("wiper0 kept", {2'h0, wiper[0]}, {2'h0, INIT});
    host_u.xfer(ADR, 8'h94, 8'h00, 2, rd, ack);
    check("read wiper1", rd, 8'h15);
    check("read wiper acks", {5'h0, ack}, 8'h06);
    // A wrong strap bit and a wrong prefix must both be ignored.
    for (int i = 0; i < 2; i++) begin
      host_u.xfer(i ? 8'h86 : 8'h97, 8'ha0, 8'h01, 1, rd, ack);
      check("foreign address acks", {5'h0, ack}, 8'h00);
      check("foreign address wiper0", {2'h0, wiper[0]}, {2'h0, INIT});
    end
    nv_frame(8'hc2, 8'h73, 1'b1);
    check("slot write leaves wiper0", {2'h0, wiper[0]}, {2'h0, INIT});
    host_u.xfer(ADR, 8'hb2, 8'h00, 2, rd, ack);
    check("read pot0 slot2", rd, 8'h33);
    host_u.xfer(ADR, 8'hb1, 8'h00, 2, rd, ack);
    check("read pot0 slot1", rd, {2'h0, INIT});
    host_u.xfer(ADR, 8'hd2, 8'h00, 0, rd, ack);
    check("slot2 to wiper0", {2'h0, wiper[0]}, 8'h33);
    host_u.xfer(ADR, 8'h24, 8'hfd, 3, rd, ack);
    check("step acks", {5'h0, ack}, 8'h06);
    check("step wiper1", {2'h0, wiper[1]}, 8'h1b);
    nv_frame(8'he7, 8'h00, 1'b0);
    host_u.xfer(ADR, 8'hb7, 8'h00, 2, rd, ack);
    check("wiper1 to slot3", rd, 8'h1b);
    nv_frame(8'h81, 8'h00, 1'b0);
    host_u.xfer(ADR, 8'hb1, 8'h00, 2, rd, ack);
    check("global copy pot0 slot1", rd, 8'h33);
    host_u.xfer(ADR, 8'hb5, 8'h00, 2, rd, ack);
    check("global copy pot1 slot1", rd, 8'h1b);
    host_u.xfer(ADR, 8'h13, 8'h00, 0, rd, ack);
    check("global recall wiper0", {2'h0, wiper[0]}, {2'h0, INIT});
    check("global recall wiper1", {2'h0, wiper[1]}, 8'h1b);
    // Stepping down past the bottom end must stop at zero.
    host_u.xfer(ADR, 8'ha0, 8'h03, 1, rd, ack);
    host_u.xfer(ADR, 8'h20, 8'h00, 3, rd, ack);
    check("step floor wiper0", {2'h0, wiper[0]}, 8'h00);
    // A set fixed zero bit makes the instruction illegal, so it and its data are ignored.
    host_u.xfer(ADR, 8'ha8, 8'h11, 1, rd, ack);
    check("illegal instr acks", {5'h0, ack}, 8'h04);
    check("illegal instr wiper0", {2'h0, wiper[0]}, 8'h00);
    // New strap levels move the device to a new address.
    strap = 4'h3;
    repeat (4) @(negedge mclk);
    host_u.xfer(8'h93, 8'ha0, 8'h05, 1, rd, ack);
    check("new strap acks", {5'h0, ack}, 8'h07);
    check("new strap wiper0", {2'h0, wiper[0]}, 8'h05);
    conclude();
  end
endmodule

`default_nettype wire
